// >>> cpu_core_regs_pkg.sv
// Constants, types and carriers for the CPU core register set.
// Assumes a 32-bit AXI4-Lite register bus and an 8-bit stack memory port.
`default_nettype none
package cpu_core_regs_pkg;
    localparam int AXI_AW = 8;
    localparam logic [7:0] OFF_ACC = 8'h00;
    localparam logic [7:0] OFF_IDX_X = 8'h04;
    localparam logic [7:0] OFF_IDX_Y = 8'h08;
    localparam logic [7:0] OFF_PC = 8'h0C;
    localparam logic [7:0] OFF_FLAGS = 8'h10;
    localparam logic [7:0] OFF_STACK = 8'h14;
    localparam logic [7:0] OFF_CMD = 8'h18;
    localparam logic [7:0] OFF_STATUS = 8'h1C;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Condition flag bit positions
    localparam int FLG_C = 0;
    localparam int FLG_Z = 1;
    localparam int FLG_N = 2;
    localparam int FLG_I0 = 3;
    localparam int FLG_H = 4;
    localparam int FLG_I1 = 5;
    localparam logic [7:0] FLAGS_RST = 8'hE8;
    localparam logic [7:0] FLAGS_FIXED = 8'hC0;
    localparam logic [1:0] PRIO_TRAP = 2'h3;
    // Stack window: upper nine bits forced
    localparam logic [8:0] SP_HIGH = 9'h003;
    localparam logic [6:0] SP_RST = 7'h7F;
    localparam logic [6:0] SP_STEP = 7'h01;
    localparam logic [2:0] LEN_CTX = 3'h5;
    localparam logic [2:0] LEN_RET = 3'h2;
    localparam logic [2:0] LEN_CC = 3'h1;
    localparam logic [2:0] ITEM_PCL = 3'h0;
    localparam logic [2:0] ITEM_PCH = 3'h1;
    localparam logic [2:0] ITEM_X = 3'h2;
    localparam logic [2:0] ITEM_A = 3'h3;
    localparam logic [2:0] ITEM_CC = 3'h4;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_PEND_BIT = 1;

    typedef enum logic [4:0] {
        OP_NOP = 5'h00, OP_LD_A = 5'h01, OP_LD_X = 5'h02, OP_LD_Y = 5'h03,
        OP_LD_S = 5'h04, OP_ADD = 5'h05, OP_ADC = 5'h06, OP_SUB = 5'h07,
        OP_AND = 5'h08, OP_SHL = 5'h09, OP_SCF = 5'h0A, OP_RCF = 5'h0B,
        OP_SIM = 5'h0C, OP_RIM = 5'h0D, OP_RSP = 5'h0E, OP_CALL = 5'h0F,
        OP_RET = 5'h10, OP_INTERRUPT_RETURN_INSTR = 5'h11, OP_TRAP = 5'h12, OP_PUSH_CC = 5'h13,
        OP_POP_CC = 5'h14
    } op_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00, ST_PUSH = 2'b01, ST_POP_REQ = 2'b10, ST_POP_CAP = 2'b11
    } seq_st_t;

    typedef enum logic [1:0] {
        K_CTX = 2'b00, K_RET = 2'b01, K_CC = 2'b10
    } seq_kind_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [2:0] rsvd;
        op_t op;
        logic [7:0] data;
    } cmd_t;

    typedef struct packed {
        logic we;
        logic re;
        logic [15:0] addr;
        logic [7:0] wdata;
    } stk_port_t;
endpackage
`default_nettype wire

// >>> cpu_core_register_set.sv
// Programmer-visible register set of an 8-bit core, with stack sequencer.
// Assumes an AXI4-Lite master on I_CLK and a stack RAM whose read data is
// valid in the cycle in which O_STK.re is high.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - One 8-bit accumulator feeds and receives ALU and load results.
// - Two 8-bit index registers; the second is never saved by interrupt context.
// - Program counter is 16 bits, low and high bytes separately handled.
// - Flags register is 8 bits with mask, four flags, pushable and poppable.
// - Flags reset to upper three bits set and bit 3 set.
// - Half carry follows carry from bit 3 to 4 on add and add-with-carry.
// - Mask bit 3 set on interrupt entry or by software; blocks all but trap.
// - Requests during mask stay pending and are taken once mask clears.
// - Negative flag copies bit 7 of each operation result.
// - Zero flag set when the result is zero, cleared otherwise.
// - Carry from arithmetic, set/clear instructions and shifts.
// - Priority bit 5 loaded on entry, bit 3 set as mask; both alterable by instructions.
// - Priority levels encode as 10, 01, 00 and 11 for levels 0 to 3.
// - Stack pointer addresses next free byte; decrement after push, increment before pop.
// - 128-byte stack, nine upper bits fixed, reset and reinit give low seven set.
// - Stack pointer wraps silently at both limits.
// - Low stack pointer byte is loadable and readable.
// - Interrupt entry writes the low program counter byte first.
// - Call uses two stack bytes, interrupt five, restored on return.
module cpu_core_register_set
(
    input wire logic I_CLK,
    input wire logic I_RESET_N,
    input wire logic I_AWVALID,
    output logic O_AWREADY,
    input wire logic [cpu_core_regs_pkg::AXI_AW-1:0] I_AWADDR,
    input wire logic I_WVALID,
    output logic O_WREADY,
    input wire logic [31:0] I_WDATA,
    input wire logic [3:0] I_WSTRB,
    output logic O_BVALID,
    input wire logic I_BREADY,
    output logic [1:0] O_BRESP,
    input wire logic I_ARVALID,
    output logic O_ARREADY,
    input wire logic [cpu_core_regs_pkg::AXI_AW-1:0] I_ARADDR,
    output logic O_RVALID,
    input wire logic I_RREADY,
    output logic [31:0] O_RDATA,
    output logic [1:0] O_RRESP,
    input wire logic I_IRQ_REQ,
    input wire logic [1:0] I_IRQ_PRIO,
    input wire logic [15:0] I_IRQ_VECTOR,
    output logic O_IRQ_ACK,
    output cpu_core_regs_pkg::stk_port_t O_STK,
    input wire logic [7:0] I_STK_RDATA
);
    import cpu_core_regs_pkg::*;

    logic [7:0] acc_ff, nxt_acc;
    logic [7:0] x_ff, nxt_x;
    logic [7:0] y_ff, nxt_y;
    logic [15:0] pc_ff, nxt_pc;
    logic [7:0] flags_ff, nxt_flags;
    logic [6:0] sp_ff, nxt_sp;
    seq_st_t st_ff, nxt_st;
    seq_kind_t kind_ff, nxt_kind;
    logic [2:0] cnt_ff, nxt_cnt;
    logic [15:0] vec_ff, nxt_vec;
    logic entry_ff, nxt_entry;
    logic [1:0] prio_ff, nxt_prio;
    logic pend_ff;
    stk_port_t stk_ff, nxt_stk;
    logic ack_ff;
    logic [AXI_AW-1:0] awaddr_ff;
    logic aw_full_ff, w_full_ff, awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
    logic [31:0] wdata_ff, rdata_ff;
    logic [3:0] wstrb_ff;
    logic [1:0] bresp_ff, rresp_ff;

    function automatic logic is_mapped(input logic [AXI_AW-1:0] a);
        return (a == OFF_ACC) || (a == OFF_IDX_X) || (a == OFF_IDX_Y) || (a == OFF_PC) ||
               (a == OFF_FLAGS) || (a == OFF_STACK) || (a == OFF_CMD) || (a == OFF_STATUS);
    endfunction

    function automatic logic [7:0] nz_flags(input logic [7:0] f, input logic [7:0] v);
        logic [7:0] r;
        r = f;
        r[FLG_N] = v[7];
        r[FLG_Z] = (v == 8'h00);
        return r;
    endfunction

    // Returns {carry, half carry, result}
    function automatic logic [9:0] alu(input op_t op, input logic [7:0] a, input logic [7:0] b,
                                       input logic cin);
        logic [8:0] s;
        logic [4:0] hs;
        logic ci;
        ci = cin & (op == OP_ADC);
        hs = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
        case (op)
            OP_ADD, OP_ADC: s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
            OP_SUB: s = {1'b0, a} - {1'b0, b};
            OP_AND: s = {cin, a & b};
            OP_SHL: s = {a, 1'b0};
            default: s = {cin, b};
        endcase
        return {s[8], hs[4], s[7:0]};
    endfunction

    function automatic logic [2:0] seq_len(input seq_kind_t k);
        return (k == K_CTX) ? LEN_CTX : ((k == K_RET) ? LEN_RET : LEN_CC);
    endfunction

    // Bus decode
    wire aw_hs = I_AWVALID & awready_ff;
    wire w_hs = I_WVALID & wready_ff;
    wire ar_hs = I_ARVALID & arready_ff;
    wire idle = (st_ff == ST_IDLE);
    // Writes wait for the sequencer, so stacked context never changes mid-push
    wire wr_go = aw_full_ff & w_full_ff & ~bvalid_ff & idle;
    wire wr_lane0 = wr_go & wstrb_ff[0];
    wire cmd_go = wr_lane0 & (awaddr_ff == OFF_CMD);
    wire cmd_t cmd = cmd_t'(wdata_ff);
    // Mask, an idle sequencer and no bus write gate entry, whatever level is running
    wire irq_go = idle & ~wr_go & pend_ff & ~flags_ff[FLG_I0];
    wire nxt_pend = I_IRQ_REQ | (pend_ff & ~irq_go);
    wire [9:0] alu_r = alu(cmd.op, acc_ff, cmd.data, flags_ff[FLG_C]);
    wire [15:0] sp_word = {SP_HIGH, sp_ff};
    wire [6:0] sp_dec = sp_ff - SP_STEP;
    wire [6:0] sp_inc = sp_ff + SP_STEP;
    wire last = (cnt_ff == seq_len(kind_ff) - 3'h1);
    wire [2:0] base = (kind_ff == K_CC) ? ITEM_CC : ITEM_PCL;
    wire [2:0] push_item = base + cnt_ff;
    wire [2:0] pop_item = base + seq_len(kind_ff) - 3'h1 - cnt_ff;
    wire [7:0] flags_rd = flags_ff | FLAGS_FIXED;
    wire [7:0] push_byte = (push_item == ITEM_PCL) ? pc_ff[7:0] :
                           (push_item == ITEM_PCH) ? pc_ff[15:8] :
                           (push_item == ITEM_X) ? x_ff :
                           (push_item == ITEM_A) ? acc_ff : flags_rd;
    wire [31:0] rd_word = (I_ARADDR == OFF_ACC) ? {24'h000000, acc_ff} :
                          (I_ARADDR == OFF_IDX_X) ? {24'h000000, x_ff} :
                          (I_ARADDR == OFF_IDX_Y) ? {24'h000000, y_ff} :
                          (I_ARADDR == OFF_PC) ? {16'h0000, pc_ff} :
                          (I_ARADDR == OFF_FLAGS) ? {24'h000000, flags_rd} :
                          (I_ARADDR == OFF_STACK) ? {16'h0000, sp_word} :
                          (I_ARADDR == OFF_STATUS) ?
                          {30'h00000000, pend_ff, ~idle} : 32'h00000000;
    wire nxt_aw_full = aw_hs | (aw_full_ff & ~wr_go);
    wire nxt_w_full = w_hs | (w_full_ff & ~wr_go);
    wire nxt_bvalid = wr_go | (bvalid_ff & ~I_BREADY);
    wire nxt_rvalid = ar_hs | (rvalid_ff & ~I_RREADY);

    always_comb
    begin
        nxt_acc = acc_ff;
        nxt_x = x_ff;
        nxt_y = y_ff;
        nxt_pc = pc_ff;
        nxt_flags = flags_ff;
        nxt_sp = sp_ff;
        nxt_st = st_ff;
        nxt_kind = kind_ff;
        nxt_cnt = cnt_ff;
        nxt_vec = vec_ff;
        nxt_entry = entry_ff;
        nxt_prio = prio_ff;
        nxt_stk = '0;
        case (st_ff)
            ST_IDLE:
            begin
                nxt_cnt = 3'h0;
                if (cmd_go)
                begin
                    case (cmd.op)
                        OP_LD_A:
                        begin
                            nxt_acc = cmd.data;
                            nxt_flags = nz_flags(flags_ff, cmd.data);
                        end
                        OP_LD_X:
                        begin
                            nxt_x = cmd.data;
                            nxt_flags = nz_flags(flags_ff, cmd.data);
                        end
                        OP_LD_Y:
                        begin
                            nxt_y = cmd.data;
                            nxt_flags = nz_flags(flags_ff, cmd.data);
                        end
                        OP_LD_S: nxt_sp = cmd.data[6:0];
                        OP_ADD, OP_ADC, OP_SUB, OP_AND, OP_SHL:
                        begin
                            nxt_acc = alu_r[7:0];
                            nxt_flags = nz_flags(flags_ff, alu_r[7:0]);
                            nxt_flags[FLG_C] = alu_r[9];
                            if (cmd.op == OP_ADD || cmd.op == OP_ADC)
                                nxt_flags[FLG_H] = alu_r[8];
                        end
                        OP_SCF: nxt_flags[FLG_C] = 1'b1;
                        OP_RCF: nxt_flags[FLG_C] = 1'b0;
                        OP_SIM:
                        begin
                            nxt_flags[FLG_I1] = 1'b1;
                            nxt_flags[FLG_I0] = 1'b1;
                        end
                        OP_RIM:
                        begin
                            nxt_flags[FLG_I1] = 1'b1;
                            nxt_flags[FLG_I0] = 1'b0;
                        end
                        OP_RSP: nxt_sp = SP_RST;
                        OP_CALL, OP_TRAP:
                        begin
                            nxt_st = ST_PUSH;
                            nxt_kind = (cmd.op == OP_CALL) ? K_RET : K_CTX;
                            nxt_vec = cmd.addr;
                            nxt_entry = (cmd.op == OP_TRAP);
                            nxt_prio = PRIO_TRAP;
                        end
                        OP_PUSH_CC:
                        begin
                            nxt_st = ST_PUSH;
                            nxt_kind = K_CC;
                            nxt_entry = 1'b0;
                        end
                        OP_RET, OP_INTERRUPT_RETURN_INSTR, OP_POP_CC:
                        begin
                            nxt_st = ST_POP_REQ;
                            nxt_kind = (cmd.op == OP_RET) ? K_RET :
                                       ((cmd.op == OP_INTERRUPT_RETURN_INSTR) ? K_CTX : K_CC);
                        end
                        default: nxt_st = ST_IDLE;
                    endcase
                end
                else if (wr_lane0)
                begin
                    if (awaddr_ff == OFF_ACC)
                        nxt_acc = wdata_ff[7:0];
                    if (awaddr_ff == OFF_IDX_X)
                        nxt_x = wdata_ff[7:0];
                    if (awaddr_ff == OFF_IDX_Y)
                        nxt_y = wdata_ff[7:0];
                    if (awaddr_ff == OFF_PC)
                        nxt_pc[7:0] = wdata_ff[7:0];
                    if (awaddr_ff == OFF_FLAGS)
                        nxt_flags = wdata_ff[7:0] | FLAGS_FIXED;
                    if (awaddr_ff == OFF_STACK)
                        nxt_sp = wdata_ff[6:0];
                end
                else if (irq_go)
                begin
                    nxt_st = ST_PUSH;
                    nxt_kind = K_CTX;
                    nxt_vec = I_IRQ_VECTOR;
                    nxt_entry = 1'b1;
                    nxt_prio = I_IRQ_PRIO;
                end
                if (wr_go && (awaddr_ff == OFF_PC) && wstrb_ff[1])
                    nxt_pc[15:8] = wdata_ff[15:8];
            end
            ST_PUSH:
            begin
                // Store at the free slot, then step down
                nxt_stk = {1'b1, 1'b0, sp_word, push_byte};
                nxt_sp = sp_dec;
                nxt_cnt = cnt_ff + 3'h1;
                if (last)
                begin
                    nxt_st = ST_IDLE;
                    if (kind_ff != K_CC)
                        nxt_pc = vec_ff;
                    if (entry_ff)
                    begin
                        // Mask wins over the loaded low priority bit
                        nxt_flags[FLG_I1] = prio_ff[1];
                        nxt_flags[FLG_I0] = 1'b1;
                    end
                end
            end
            ST_POP_REQ:
            begin
                nxt_sp = sp_inc;
                nxt_stk = {1'b0, 1'b1, SP_HIGH, sp_inc, 8'h00};
                nxt_st = ST_POP_CAP;
            end
            ST_POP_CAP:
            begin
                case (pop_item)
                    ITEM_PCL: nxt_pc[7:0] = I_STK_RDATA;
                    ITEM_PCH: nxt_pc[15:8] = I_STK_RDATA;
                    ITEM_X: nxt_x = I_STK_RDATA;
                    ITEM_A: nxt_acc = I_STK_RDATA;
                    default: nxt_flags = I_STK_RDATA | FLAGS_FIXED;
                endcase
                nxt_cnt = cnt_ff + 3'h1;
                nxt_st = last ? ST_IDLE : ST_POP_REQ;
            end
            default: nxt_st = ST_IDLE;
        endcase
    end

    always_ff @(posedge I_CLK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
        begin
            acc_ff <= 8'h00;
            x_ff <= 8'h00;
            y_ff <= 8'h00;
            pc_ff <= 16'h0000;
            flags_ff <= FLAGS_RST;
            sp_ff <= SP_RST;
            st_ff <= ST_IDLE;
            kind_ff <= K_CTX;
            cnt_ff <= 3'h0;
            vec_ff <= 16'h0000;
            entry_ff <= 1'b0;
            prio_ff <= 2'h0;
            pend_ff <= 1'b0;
            stk_ff <= '0;
            ack_ff <= 1'b0;
        end
        else
        begin
            acc_ff <= nxt_acc;
            x_ff <= nxt_x;
            y_ff <= nxt_y;
            pc_ff <= nxt_pc;
            flags_ff <= nxt_flags;
            sp_ff <= nxt_sp;
            st_ff <= nxt_st;
            kind_ff <= nxt_kind;
            cnt_ff <= nxt_cnt;
            vec_ff <= nxt_vec;
            entry_ff <= nxt_entry;
            prio_ff <= nxt_prio;
            pend_ff <= nxt_pend;
            stk_ff <= nxt_stk;
            ack_ff <= irq_go;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
        begin
            awaddr_ff <= '0;
            wdata_ff <= 32'h00000000;
            wstrb_ff <= 4'h0;
            aw_full_ff <= 1'b0;
            w_full_ff <= 1'b0;
            awready_ff <= 1'b0;
            wready_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
            rresp_ff <= RESP_OKAY;
        end
        else
        begin
            if (aw_hs)
                awaddr_ff <= I_AWADDR;
            if (w_hs)
                wdata_ff <= I_WDATA;
            if (w_hs)
                wstrb_ff <= I_WSTRB;
            aw_full_ff <= nxt_aw_full;
            w_full_ff <= nxt_w_full;
            awready_ff <= ~nxt_aw_full;
            wready_ff <= ~nxt_w_full;
            bvalid_ff <= nxt_bvalid;
            if (wr_go)
                bresp_ff <= is_mapped(awaddr_ff) ? RESP_OKAY : RESP_SLVERR;
            arready_ff <= ~nxt_rvalid;
            rvalid_ff <= nxt_rvalid;
            if (ar_hs)
                rdata_ff <= rd_word;
            if (ar_hs)
                rresp_ff <= is_mapped(I_ARADDR) ? RESP_OKAY : RESP_SLVERR;
        end
    end

    assign O_AWREADY = awready_ff;
    assign O_WREADY = wready_ff;
    assign O_BVALID = bvalid_ff;
    assign O_BRESP = bresp_ff;
    assign O_ARREADY = arready_ff;
    assign O_RVALID = rvalid_ff;
    assign O_RDATA = rdata_ff;
    assign O_RRESP = rresp_ff;
    assign O_IRQ_ACK = ack_ff;
    assign O_STK = stk_ff;

    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RESET_N);

    a_stack_window: assert property ((O_STK.we | O_STK.re) |-> O_STK.addr[15:7] == SP_HIGH)
        else $error("stack access outside window");
    a_push_steps_down: assert property (st_ff == ST_PUSH |=> sp_ff == 7'($past(sp_ff) - 7'h01))
        else $error("push did not decrement stack pointer");
    a_pop_addr_up: assert property (st_ff == ST_POP_REQ |=> O_STK.re && O_STK.addr[6:0] == sp_ff)
        else $error("pop address not pre-incremented");
    a_ctx_five_bytes: assert property (irq_go |=> ##1 O_STK.we [*5] ##1 !O_STK.we)
        else $error("interrupt context not five bytes");
    a_ctx_pcl_first: assert property (irq_go |-> ##2 O_STK.wdata == pc_ff[7:0])
        else $error("low program counter byte not pushed first");
    a_mask_on_entry: assert property (irq_go |-> ##6 flags_ff[FLG_I0] && pc_ff == $past(I_IRQ_VECTOR, 6))
        else $error("entry did not set mask and vector");
    a_masked_no_entry: assert property (flags_ff[FLG_I0] |-> !irq_go)
        else $error("interrupt taken while masked");
    a_pending_held: assert property (pend_ff && flags_ff[FLG_I0] |=> pend_ff)
        else $error("pending request lost under mask");
    a_load_nz: assert property (cmd_go && cmd.op == OP_LD_A |=> flags_ff[FLG_N] == acc_ff[7] && flags_ff[FLG_Z] == (acc_ff == 8'h00))
        else $error("load flags wrong");
    a_half_carry: assert property (cmd_go && cmd.op == OP_ADD |=> flags_ff[FLG_H] == (({1'b0, $past(acc_ff[3:0])} + {1'b0, $past(cmd.data[3:0])}) > 5'h0F))
        else $error("half carry wrong");
    a_y_not_stacked: assert property (!idle |=> $stable(y_ff))
        else $error("second index register changed by stacking");
    a_reinit_sp: assert property (cmd_go && cmd.op == OP_RSP |=> sp_word == {SP_HIGH, SP_RST})
        else $error("stack pointer reinit wrong");

    c_irq_entry: cover property (irq_go ##6 idle);
    c_interrupt_return_instr: cover property (cmd_go && cmd.op == OP_INTERRUPT_RETURN_INSTR ##10 idle);
    c_call: cover property (cmd_go && cmd.op == OP_CALL);
    c_sp_wrap: cover property (st_ff == ST_PUSH && sp_ff == 7'h00);
endmodule
`default_nettype wire

// >>> cpu_core_register_set_tb.sv
// Testbench for the CPU core register set: reset, then a command table,
// interrupt and trap cases. Assumes the design's AXI4-Lite slave and a
// stack RAM modelled here with same-cycle read data.
`timescale 1ns/1ps
`default_nettype none
module cpu_core_register_set_tb;
    import cpu_core_regs_pkg::*;
    typedef struct packed {op_t op; logic [15:0] ad; logic [7:0] dat; logic [7:0] off;
        logic [15:0] ex;} row_t;
    logic I_CLK = 1'b0, I_RESET_N = 1'b0, I_AWVALID = 1'b0, I_WVALID = 1'b0, I_BREADY = 1'b1;
    logic I_ARVALID = 1'b0, I_RREADY = 1'b1, I_IRQ_REQ = 1'b0;
    logic O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID, O_IRQ_ACK;
    logic [7:0] I_AWADDR = 8'h00, I_ARADDR = 8'h00, I_STK_RDATA;
    logic [31:0] I_WDATA = 32'h0, O_RDATA, d;
    logic [3:0] I_WSTRB = 4'hF;
    logic [1:0] O_BRESP, O_RRESP, r, I_IRQ_PRIO = 2'h0;
    logic [15:0] I_IRQ_VECTOR = 16'h0;
    stk_port_t O_STK;
    logic [7:0] mem [128];
    logic [23:0] log_q [$];
    logic [23:0] ctx [4] = '{24'h01FF21, 24'h01FE43, 24'h01FD55, 24'h01FC3C};
    int error_cnt = 0, cmp_count = 0, cyc = 0, acks = 0;
    // Expected flags follow the running state from reset
    row_t rows [22] = '{'{OP_LD_A, 16'h0, 8'h80, OFF_FLAGS, 16'hEC},
        '{OP_ADD, 16'h0, 8'h80, OFF_FLAGS, 16'hEB}, '{OP_ADC, 16'h0, 8'h0F, OFF_ACC, 16'h10},
        '{OP_NOP, 16'h0, 8'h0, OFF_FLAGS, 16'hF8}, '{OP_LD_X, 16'h0, 8'h55, OFF_IDX_X, 16'h55},
        '{OP_LD_Y, 16'h0, 8'hAA, OFF_IDX_Y, 16'hAA}, '{OP_SCF, 16'h0, 8'h0, OFF_FLAGS, 16'hFD},
        '{OP_RCF, 16'h0, 8'h0, OFF_FLAGS, 16'hFC}, '{OP_SUB, 16'h0, 8'h20, OFF_FLAGS, 16'hFD},
        '{OP_AND, 16'h0, 8'h0F, OFF_FLAGS, 16'hFB}, '{OP_LD_A, 16'h0, 8'h81, OFF_ACC, 16'h81},
        '{OP_SHL, 16'h0, 8'h0, OFF_FLAGS, 16'hF9}, '{OP_RIM, 16'h0, 8'h0, OFF_FLAGS, 16'hF1},
        '{OP_SIM, 16'h0, 8'h0, OFF_FLAGS, 16'hF9}, '{OP_LD_S, 16'h0, 8'h10, OFF_STACK, 16'h190},
        '{OP_RSP, 16'h0, 8'h0, OFF_STACK, 16'h1FF}, '{OP_CALL, 16'h1234, 8'h0, OFF_STACK, 16'h1FD},
        '{OP_NOP, 16'h0, 8'h0, OFF_PC, 16'h1234}, '{OP_RET, 16'h0, 8'h0, OFF_PC, 16'h0},
        '{OP_LD_S, 16'h0, 8'h00, OFF_STACK, 16'h180}, '{OP_PUSH_CC, 16'h0, 8'h0, OFF_STACK, 16'h1FF},
        '{OP_POP_CC, 16'h0, 8'h0, OFF_STACK, 16'h180}};
    cpu_core_register_set i_cpu_core_register_set (.I_CLK(I_CLK), .I_RESET_N(I_RESET_N),
        .I_AWVALID(I_AWVALID), .O_AWREADY(O_AWREADY), .I_AWADDR(I_AWADDR), .I_WVALID(I_WVALID),
        .O_WREADY(O_WREADY), .I_WDATA(I_WDATA), .I_WSTRB(I_WSTRB), .O_BVALID(O_BVALID),
        .I_BREADY(I_BREADY), .O_BRESP(O_BRESP), .I_ARVALID(I_ARVALID), .O_ARREADY(O_ARREADY),
        .I_ARADDR(I_ARADDR), .O_RVALID(O_RVALID), .I_RREADY(I_RREADY), .O_RDATA(O_RDATA),
        .O_RRESP(O_RRESP), .I_IRQ_REQ(I_IRQ_REQ), .I_IRQ_PRIO(I_IRQ_PRIO),
        .I_IRQ_VECTOR(I_IRQ_VECTOR), .O_IRQ_ACK(O_IRQ_ACK), .O_STK(O_STK),
        .I_STK_RDATA(I_STK_RDATA));
    assign I_STK_RDATA = mem[O_STK.addr[6:0]];
    always #50 I_CLK = ~I_CLK;
    task automatic stop_test();
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Stack RAM and push log; ready lines stay high, which the bus allows
    always @(posedge I_CLK)
    begin
        cyc <= cyc + 1;
        if (O_STK.we === 1'b1)
        begin
            mem[O_STK.addr[6:0]] <= O_STK.wdata;
            log_q.push_back({O_STK.addr, O_STK.wdata});
        end
        if (O_IRQ_ACK === 1'b1)
            acks <= acks + 1;
        if (cyc == 20000)
        begin
            error_cnt++;
            stop_test();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] ex);
        cmp_count++;
        if (got !== ex)
        begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, got, ex);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] dt, output logic [1:0] br);
        logic b;
        b = 1'b0;
        I_AWADDR <= a;
        I_WDATA <= dt;
        I_AWVALID <= 1'b1;
        I_WVALID <= 1'b1;
        while (!b)
        begin
            @(posedge I_CLK);
            if (I_AWVALID && O_AWREADY) I_AWVALID <= 1'b0;
            if (I_WVALID && O_WREADY) I_WVALID <= 1'b0;
            if (O_BVALID === 1'b1) b = 1'b1;
            br = O_BRESP;
        end
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] dt, output logic [1:0] rr);
        logic g;
        g = 1'b0;
        I_ARADDR <= a;
        I_ARVALID <= 1'b1;
        while (!g)
        begin
            @(posedge I_CLK);
            if (I_ARVALID && O_ARREADY) I_ARVALID <= 1'b0;
            if (O_RVALID === 1'b1) g = 1'b1;
            dt = O_RDATA;
            rr = O_RRESP;
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] ex);
        rd(a, d, r);
        chk(d, ex);
    endtask
    // Waits on the busy bit so the next step sees a finished sequence
    task automatic cmd(input op_t op, input logic [15:0] ad, input logic [7:0] dt);
        wr(OFF_CMD, {ad, 3'h0, op, dt}, r);
        do rd(OFF_STATUS, d, r); while (d[ST_BUSY_BIT] !== 1'b0);
    endtask
    initial
    begin
        repeat (2) @(posedge I_CLK);
        I_RESET_N <= 1'b1;
        @(posedge I_CLK);
        rchk(OFF_FLAGS, 32'hE8);
        rchk(OFF_STACK, 32'h1FF);
        rchk(OFF_ACC, 32'h0);
        rd(8'h20, d, r);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        wr(8'h24, 32'h1, r);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        $display("test reset done");
        foreach (rows[i])
        begin
            cmd(rows[i].op, rows[i].ad, rows[i].dat);
            rchk(rows[i].off, {16'h0, rows[i].ex});
        end
        $display("test table done");
        wr(OFF_PC, 32'h4321, r);
        rchk(OFF_PC, 32'h4321);
        cmd(OP_RSP, 16'h0, 8'h0);
        cmd(OP_LD_A, 16'h0, 8'h3C);
        I_IRQ_PRIO <= 2'b01;
        I_IRQ_VECTOR <= 16'h8000;
        I_IRQ_REQ <= 1'b1;
        @(posedge I_CLK);
        I_IRQ_REQ <= 1'b0;
        repeat (20) @(posedge I_CLK);
        chk(acks, 0);
        rchk(OFF_STATUS, 32'h2);
        log_q.delete();
        cmd(OP_RIM, 16'h0, 8'h0);
        repeat (20) @(posedge I_CLK);
        chk(log_q.size(), 5);
        foreach (ctx[i]) chk(log_q[i], ctx[i]);
        chk(acks, 1);
        rchk(OFF_PC, 32'h8000);
        rd(OFF_FLAGS, d, r);
        chk(d & 32'h28, 32'h08);
        rchk(OFF_STACK, 32'h1FA);
        cmd(OP_LD_A, 16'h0, 8'h0);
        cmd(OP_LD_X, 16'h0, 8'h0);
        cmd(OP_INTERRUPT_RETURN_INSTR, 16'h0, 8'h0);
        rchk(OFF_ACC, 32'h3C);
        rchk(OFF_IDX_X, 32'h55);
        rchk(OFF_PC, 32'h4321);
        rchk(OFF_STACK, 32'h1FF);
        $display("test interrupt done");
        cmd(OP_SIM, 16'h0, 8'h0);
        cmd(OP_TRAP, 16'h8000, 8'h0);
        repeat (20) @(posedge I_CLK);
        rchk(OFF_STACK, 32'h1FA);
        rchk(OFF_PC, 32'h8000);
        $display("test trap done");
        stop_test();
    end
endmodule
`default_nettype wire
